// ### bench/ues_event_selector_test.sv
// Random bench for the uncore event selector
`timescale 1ns/1ns
`default_nettype none
module ues_event_selector_test;
    import ues_pkg::*;
    logic mclk = '0, rst = '1, countEnable = '0, counterClear = '0, rasMode = '0, h;
    logic reqReady, reqSleeping, countPulse, matchUnsupported, schedEligible;
    logic [2:0] e = '0, m;
    logic [47:0] count, cExp = '0;
    logic [67:0] matchValue = '0;
    logic [67:0] pats [5] = '{'0, 68'h40000000000000, 68'h40001a0000000000,
        68'h40001d00000000000, 68'h1};
    logic [7:0] evs [6] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h40};
    ues_sel_t sel = '0;
    ues_strobe_t strobes;
    int seed = 71105, miscompares = 0, checked = 0, cycles = 0, r, mi;
    always #2 mclk = ~mclk;
    ues_event_selector u_ues_event_selector (
        .mclk(mclk), .rst(rst), .sel(sel), .countEnable(countEnable),
        .counterClear(counterClear), .matchValue(matchValue), .rasMode(rasMode),
        .strobes(strobes), .reqReady(reqReady), .reqSleeping(reqSleeping), .count(count),
        .countPulse(countPulse), .matchUnsupported(matchUnsupported),
        .schedEligible(schedEligible)
    );
    ues_far_side u_ues_far_side (
        .mclk(mclk), .rst(rst), .strobes(strobes), .reqReady(reqReady),
        .reqSleeping(reqSleeping)
    );
    task automatic compare(string n, logic [47:0] x, logic [47:0] g);
        checked++;
        if (x !== g) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : compare
    task automatic summarize;
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        if (++cycles == 4000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(negedge mclk);
        for (int i = 0; i < 3000; i++) begin
            @(negedge mclk);
            compare("count", cExp, count);
            compare("flags", e, {countPulse, matchUnsupported, schedEligible});
            r = $random(seed);
            mi = r[26:24] % 5;
            rst <= i == 1500;
            // Corner cases: every event with all mask bits, counting and reliability mode on
            sel <= i % 100 < 6 ? {evs[i % 100], 8'h3f} : {r[3] ? 5'h08 : 5'h06, r[2:0], r[15:8]};
            {countEnable, rasMode} <= i % 100 < 6 ? 2'b11 : r[17:16];
            counterClear <= i % 100 >= 6 && r[21:18] == 0;
            matchValue <= pats[mi];
            #1;
            m = sel.umask[2:0];
            case (sel.evSel)
                8'h31: h = |(m & strobes.prioUpdate);
                8'h32: h = rasMode && |(m & strobes.retry);
                8'h33: h = |(m & strobes.frcAck);
                8'h34: h = |(m & strobes.sleepOrder | sel.umask[5:3] & strobes.sleepAddr);
                8'h35: h = mi > 0 && mi == strobes.reqRsp && |(m & strobes.reqValid);
                8'h40: h = |(m & strobes.txStall);
                default: h = 1'b0;
            endcase
            e = {h && !rst && countEnable && !counterClear, !rst && mi == 4,
                !rst && reqReady && !reqSleeping};
            cExp = rst || counterClear ? '0 : cExp + e[2];
        end
        summarize();
    end
endmodule : ues_event_selector_test
`default_nettype wire

// ### bench/ues_far_side.sv
// Far-side unit model: event strobes and request state
`timescale 1ns/1ns
`default_nettype none
module ues_far_side (
    input wire logic mclk,
    input wire logic rst,
    output ues_pkg::ues_strobe_t strobes,
    output logic reqReady,
    output logic reqSleeping
);
    int seed = 71105;
    always @(negedge mclk)
        {strobes, reqReady, reqSleeping} <= rst ? '0 : 25'($random(seed));
endmodule : ues_far_side
`default_nettype wire

// ### bench/ues_monitor.sv
// Port checker for the uncore event selector
`timescale 1ns/1ns
`default_nettype none
module ues_monitor #(parameter int CNT_W = 48, MATCH_W = 68) (
    input wire logic mclk, rst, countEnable, counterClear, rasMode, reqSleeping,
    input wire ues_pkg::ues_sel_t sel,
    input wire ues_pkg::ues_strobe_t strobes,
    input wire logic [MATCH_W-1:0] matchValue,
    input wire logic [CNT_W-1:0] count,
    input wire logic countPulse, matchUnsupported, schedEligible
);
    import ues_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic go = countEnable && !counterClear;
    a_sleep_gate: assert property ($past(reqSleeping) |-> !schedEligible)
        else $error("sleep");
    a_pulse_step: assert property (countPulse |-> count == $past(count) + 1'b1)
        else $error("step");
    a_idle_hold: assert property (!countPulse && !$past(counterClear) |-> $stable(count))
        else $error("hold");
    a_retry_ras: assert property (sel.evSel == 8'h32 && !rasMode |=> !countPulse)
        else $error("retry");
    a_prio_ch2: assert property (go && sel.evSel == 8'h31
        && sel.umask[2] && strobes.prioUpdate[2] |=> countPulse) else $error("prio");
    a_stall_any: assert property (go && sel.evSel == 8'h40
        && |(sel.umask[2:0] & strobes.txStall) |=> countPulse) else $error("stall");
    a_addr_sleep: assert property (go && sel.evSel == 8'h34
        && |(sel.umask[5:3] & strobes.sleepAddr) |=> countPulse) else $error("conflict");
    a_match_bad: assert property (matchValue == 'h1 |=> matchUnsupported)
        else $error("match");
    c_pulse: cover property (countPulse);
    c_sched: cover property (schedEligible);
    c_bad: cover property (matchUnsupported);
endmodule : ues_monitor
bind ues_event_selector ues_monitor #(.CNT_W(CNT_W), .MATCH_W(MATCH_W)) u_ues_monitor (
    .mclk(mclk), .rst(rst), .countEnable(countEnable), .counterClear(counterClear),
    .rasMode(rasMode), .reqSleeping(reqSleeping), .sel(sel), .strobes(strobes),
    .matchValue(matchValue), .count(count), .countPulse(countPulse),
    .matchUnsupported(matchUnsupported), .schedEligible(schedEligible)
);
`default_nettype wire

// ### design/ues_defs.svh
// Event codes, unit-mask fields, match patterns and widths for the uncore event selector
// Contract
// R1: Event 31H counts memory-controller priority updates, mask 04H channel 2, 07H any channel.
// R2: A priority update is the home agent expediting a normal-priority request on an isochronous hit.
// R3: Event 32H counts memory retries, masks 01H, 02H, 04H per channel 0..2 and 07H any channel.
// R4: Retries are counted only while the memory controller is in reliability mode.
// R5: Event 33H counts force-acknowledge conflicts, 01H io hub, 02H remote, 04H local, 07H all.
// R6: Event 34H counts ordering sleeps, 01H io hub, 02H remote socket, 04H local socket.
// R7: Event 34H counts address-conflict sleeps, 08H io hub, 10H remote socket, 20H local socket.
// R8: A sleeping request is never made eligible for scheduling to the memory controller.
// R9: Event 35H counts requests that satisfy the match register, 01H io hub, 02H remote, 04H local.
// R10: The match register holds zero or one of three response patterns, each decoded.
// R11: Event 40H counts link-0 stall cycles, 01H home, 02H snoop, 04H non-data response.
// R12: A stall cycle counts even when arbitration granted another virtual channel.
// R13: Each mask bit enables one sub-event and several active sub-events give one increment.
`ifndef UES_DEFS_SVH
`define UES_DEFS_SVH

`define UES_EVSEL_W 8
`define UES_UMASK_W 8
`define UES_CNT_W 48
`define UES_MATCH_W 68

`define UES_EV_PRIO_UPDATE 8'h31
`define UES_EV_RETRY 8'h32
`define UES_EV_FRC_ACK 8'h33
`define UES_EV_SLEEP 8'h34
`define UES_EV_ADDR_MATCH 8'h35
`define UES_EV_TX_STALL 8'h40

`define UES_UM_LO_POS 0
`define UES_UM_HI_POS 3
`define UES_UM_FIELD_W 3

`define UES_MATCH_NONE 68'h0
`define UES_MATCH_FWD_INV 68'h40000000000000
`define UES_MATCH_FWD_SHR 68'h40001a0000000000
`define UES_MATCH_INV_WB 68'h40001d00000000000

`define UES_CNT_RESET 48'h0

`endif

// ### design/ues_event_selector.sv
// Uncore event selector and counter with match decode and sleep gating
`timescale 1ns/1ns
`default_nettype none
`include "ues_defs.svh"

module ues_event_selector #(
    parameter int CNT_W = `UES_CNT_W,
    parameter int MATCH_W = `UES_MATCH_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Software selection
    input wire ues_pkg::ues_sel_t sel,
    input wire logic countEnable,
    input wire logic counterClear,
    input wire logic [MATCH_W-1:0] matchValue,
    input wire logic rasMode,
    // Unit strobes
    input wire ues_pkg::ues_strobe_t strobes,
    // Home agent scheduling
    input wire logic reqReady,
    input wire logic reqSleeping,
    // Results
    output logic [CNT_W-1:0] count,
    output logic countPulse,
    output logic matchUnsupported,
    output logic schedEligible
);
    import ues_pkg::*;

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic countPulse_r;
    logic countPulse_nxt;
    logic matchBad_r;
    logic matchBad_nxt;
    logic schedEligible_r;
    logic schedEligible_nxt;

    ues_rsp_t matchRsp;
    logic matchOk;
    logic [`UES_UM_FIELD_W-1:0] umLo;
    logic [`UES_UM_FIELD_W-1:0] umHi;
    logic [2:0] matchHits;
    logic hit;

    assign umLo = sel.umask[`UES_UM_LO_POS +: `UES_UM_FIELD_W];
    assign umHi = sel.umask[`UES_UM_HI_POS +: `UES_UM_FIELD_W];

    // Match register decode
    always_comb begin
        matchRsp = UES_RSP_NONE;
        matchOk = 1'b1;
        if (matchValue == MATCH_W'(`UES_MATCH_NONE)) begin
            matchRsp = UES_RSP_NONE; // R10
        end else if (matchValue == MATCH_W'(`UES_MATCH_FWD_INV)) begin
            matchRsp = UES_RSP_FWD_INV; // R10
        end else if (matchValue == MATCH_W'(`UES_MATCH_FWD_SHR)) begin
            matchRsp = UES_RSP_FWD_SHR; // R10
        end else if (matchValue == MATCH_W'(`UES_MATCH_INV_WB)) begin
            matchRsp = UES_RSP_INV_WB; // R10
        end else begin
            matchOk = 1'b0;
        end
    end

    // A zero or unsupported match value never matches
    always_comb begin
        matchHits = 3'h0;
        if (matchOk && matchRsp != UES_RSP_NONE && strobes.reqRsp == matchRsp) begin
            matchHits = strobes.reqValid; // R9
        end
    end

    // Sub-event selection, one increment per cycle at most
    always_comb begin
        hit = 1'b0;
        unique case (sel.evSel)
            `UES_EV_PRIO_UPDATE: begin
                hit = |(strobes.prioUpdate & umLo); // R1 R2 R13
            end
            `UES_EV_RETRY: begin
                hit = rasMode && |(strobes.retry & umLo); // R3 R4 R13
            end
            `UES_EV_FRC_ACK: begin
                hit = |(strobes.frcAck & umLo); // R5 R13
            end
            `UES_EV_SLEEP: begin
                hit = |(strobes.sleepOrder & umLo) || |(strobes.sleepAddr & umHi); // R6 R7 R13
            end
            `UES_EV_ADDR_MATCH: begin
                hit = |(matchHits & umLo); // R9 R13
            end
            `UES_EV_TX_STALL: begin
                // Arbitration grant is deliberately not looked at
                hit = |(strobes.txStall & umLo); // R11 R12 R13
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Counter and status next values
    always_comb begin
        count_nxt = count_r;
        countPulse_nxt = 1'b0;
        if (counterClear) begin
            count_nxt = '0;
        end else if (countEnable && hit) begin
            count_nxt = count_r + CNT_W'(1);
            countPulse_nxt = 1'b1;
        end
        matchBad_nxt = ~matchOk;
        schedEligible_nxt = reqReady && !reqSleeping; // R8
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_r <= CNT_W'(`UES_CNT_RESET);
            countPulse_r <= 1'b0;
            matchBad_r <= 1'b0;
            schedEligible_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            countPulse_r <= countPulse_nxt;
            matchBad_r <= matchBad_nxt;
            schedEligible_r <= schedEligible_nxt;
        end
    end

    assign count = count_r;
    assign countPulse = countPulse_r;
    assign matchUnsupported = matchBad_r;
    assign schedEligible = schedEligible_r;

endmodule : ues_event_selector
`default_nettype wire

// ### design/ues_pkg.sv
// Types shared by the uncore event selector
`include "ues_defs.svh"

package ues_pkg;

    typedef enum logic [1:0] {
        UES_RSP_NONE = 2'b00,
        UES_RSP_FWD_INV = 2'b01,
        UES_RSP_FWD_SHR = 2'b10,
        UES_RSP_INV_WB = 2'b11
    } ues_rsp_t;

    // Per-source strobes: bit 0 io hub, channel 0 or home, bit 1 remote, ch 1 or snoop, bit 2 local, ch 2 or non-data response
    typedef struct packed {
        logic [2:0] prioUpdate;
        logic [2:0] retry;
        logic [2:0] frcAck;
        logic [2:0] sleepOrder;
        logic [2:0] sleepAddr;
        logic [2:0] reqValid;
        ues_rsp_t reqRsp;
        logic [2:0] txStall;
    } ues_strobe_t;

    typedef struct packed {
        logic [`UES_EVSEL_W-1:0] evSel;
        logic [`UES_UMASK_W-1:0] umask;
    } ues_sel_t;

endpackage : ues_pkg
